// ===== cds_top.sv
// Sample-clock divider with sync alignment, duty restorer and reference select
//
// Summary of operation
// - Sample clock is divided by any integer ratio from one to eight.
// - sync_control bits one and two pick resync on every pulse or first only.
// - An accepted sync forces the divider back to its initial count.
// - The sync pin passes through a two-flop synchroniser on the sample clock.
// - With the duty restorer on, the conversion clock is regenerated near half duty.
// - The duty restorer is not usable below a twenty megahertz sample clock.
// - Sense near ground selects internal reference; sense at supply selects external.
// - Each sample is taken on the rising edge of the conversion clock.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/100ps
module cds_top
    import cds_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // External sync and reference sense comparators
    input wire logic sync_in,
    input wire logic sense_low,
    input wire logic sense_high,
    // Clock and reference outputs
    output logic conv_clk,
    output logic sample_strobe,
    output logic ref_internal,
    output logic ref_external
);

    typedef struct packed {
        logic [7:0] sync_control;
        logic [7:0] div_control;
        logic armed;
        logic sync_prev;
        logic realign;
        cds_relock_t relock;
        logic [RELOCK_W-1:0] relock_cnt;
        logic waitrequest;
        logic [DATA_W-1:0] readdata;
        logic ref_internal;
        logic ref_external;
    } cds_top_state_t;

    cds_top_state_t st;
    cds_top_state_t next_st;

    logic sync_q;
    logic [CNT_W-1:0] phase;
    logic sync_rise;
    logic sync_en;
    logic one_shot;
    logic accept;
    logic bus_req;
    logic bus_done;
    logic wr_sync;
    logic wr_div;
    logic div_change;
    logic restorer_active;
    logic [7:0] wdata;

    // Sync pin into the sample-clock domain
    cds_sync2 u_sync (
        .clk(clk),
        .srst(srst),
        .d(sync_in),
        .q(sync_q)
    );

    cds_divider u_div (
        .clk(clk),
        .srst(srst),
        .ratio_m1(st.div_control[DC_RATIO_LSB +: CNT_W]),
        .restorer_on(restorer_active),
        .realign(st.realign),
        .conv_clk(conv_clk),
        .sample_strobe(sample_strobe),
        .phase(phase)
    );

    always_comb
    begin
        next_st = st;
        wdata = avs_writedata[7:0];
        sync_rise = sync_q && !st.sync_prev;
        sync_en = st.sync_control[SC_SYNC_EN_BIT];
        one_shot = st.sync_control[SC_ONE_SHOT_BIT];
        // Qualify the edge by mode and one-shot arming
        accept = sync_rise && sync_en && (!one_shot || st.armed);
        bus_req = avs_read || avs_write;
        bus_done = bus_req && !st.waitrequest;
        wr_sync = avs_write && bus_done && avs_byteenable[0]
            && (cds_decode(avs_address) == CDS_SEL_SYNC);
        wr_div = avs_write && bus_done && avs_byteenable[0]
            && (cds_decode(avs_address) == CDS_SEL_DIV);
        div_change = wr_div && ((wdata & DIV_CONTROL_MASK) != st.div_control);
        // Restorer loop only meaningful at or above its minimum rate
        restorer_active = st.div_control[DC_RESTORER_BIT] && RESTORER_SUPPORTED;

        next_st.sync_prev = sync_q;
        next_st.realign = accept;
        if (accept && one_shot)
            next_st.armed = 1'b0;
        // A write rearms even if a sync is accepted in the same cycle
        if (wr_sync)
        begin
            next_st.sync_control = wdata & SYNC_CONTROL_MASK;
            next_st.armed = 1'b1;
        end
        if (wr_div)
            next_st.div_control = wdata & DIV_CONTROL_MASK;

        // Relock tracking after the internal clock rate changes
        case (st.relock)
            CDS_RL_IDLE:
            begin
                next_st.relock_cnt = '0;
                if (restorer_active)
                    next_st.relock = CDS_RL_WAIT;
            end
            CDS_RL_WAIT:
            begin
                if (st.relock_cnt == RELOCK_W'(RELOCK_CYCLES - 1))
                    next_st.relock = CDS_RL_LOCKED;
                else
                    next_st.relock_cnt = st.relock_cnt + 6'h01;
            end
            CDS_RL_LOCKED:
                next_st.relock_cnt = '0;
            default:
            begin
                next_st.relock = CDS_RL_IDLE;
                next_st.relock_cnt = '0;
            end
        endcase
        if (!restorer_active)
        begin
            next_st.relock = CDS_RL_IDLE;
            next_st.relock_cnt = '0;
        end
        else if (div_change)
        begin
            next_st.relock = CDS_RL_WAIT;
            next_st.relock_cnt = '0;
        end

        // One wait cycle per request; read data captured with it
        next_st.waitrequest = !(bus_req && st.waitrequest);
        if (avs_read && st.waitrequest)
        begin
            case (cds_decode(avs_address))
                CDS_SEL_SYNC:
                    next_st.readdata = {24'h000000, st.sync_control};
                CDS_SEL_DIV:
                    next_st.readdata = {24'h000000, st.div_control};
                CDS_SEL_STATUS:
                begin
                    next_st.readdata = 32'h00000000;
                    next_st.readdata[ST_ARMED_BIT] = st.armed;
                    next_st.readdata[ST_RESTORER_BIT] = restorer_active;
                    next_st.readdata[ST_LOCKED_BIT] = (st.relock == CDS_RL_LOCKED);
                    next_st.readdata[ST_REF_INT_BIT] = st.ref_internal;
                    next_st.readdata[ST_REF_EXT_BIT] = st.ref_external;
                    next_st.readdata[ST_PHASE_LSB +: CNT_W] = phase;
                end
                default:
                    next_st.readdata = 32'h00000000;
            endcase
        end

        // Reference mode from the sense comparators
        next_st.ref_internal = sense_low;
        next_st.ref_external = sense_high && !sense_low;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st <= '0;
            st.sync_control <= SYNC_CONTROL_RST;
            st.div_control <= DIV_CONTROL_RST;
            st.relock <= CDS_RL_IDLE;
            st.waitrequest <= 1'b1;
        end
        else
            st <= next_st;
    end

    assign avs_readdata = st.readdata;
    assign avs_waitrequest = st.waitrequest;
    assign ref_internal = st.ref_internal;
    assign ref_external = st.ref_external;

    property p_bus_ack;
        @(posedge clk) disable iff (srst)
        bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_bus_ack: assert property (p_bus_ack)
        else $error("waitrequest did not drop for exactly one cycle");

    property p_write_sync;
        @(posedge clk) disable iff (srst)
        wr_sync |=> st.sync_control == ($past(wdata) & SYNC_CONTROL_MASK) && st.armed;
    endproperty
    a_write_sync: assert property (p_write_sync)
        else $error("sync_control write not stored or one-shot not rearmed");

    property p_accept_realign;
        @(posedge clk) disable iff (srst)
        sync_rise && sync_en && !one_shot |=> st.realign ##1 sample_strobe && phase == 3'h0;
    endproperty
    a_accept_realign: assert property (p_accept_realign)
        else $error("accepted sync did not reset the divider");

    property p_oneshot_disarm;
        @(posedge clk) disable iff (srst)
        accept && one_shot && !wr_sync |=> !st.armed;
    endproperty
    a_oneshot_disarm: assert property (p_oneshot_disarm)
        else $error("one-shot stayed armed after an accepted sync");

    property p_oneshot_ignore;
        @(posedge clk) disable iff (srst)
        sync_rise && one_shot && !st.armed |=> !st.realign;
    endproperty
    a_oneshot_ignore: assert property (p_oneshot_ignore)
        else $error("sync acted while one-shot was disarmed");

    property p_no_sync_when_off;
        @(posedge clk) disable iff (srst)
        !sync_en |=> !st.realign;
    endproperty
    a_no_sync_when_off: assert property (p_no_sync_when_off)
        else $error("divider realigned with sync disabled");

    property p_restorer_gate;
        @(posedge clk) disable iff (srst)
        !st.div_control[DC_RESTORER_BIT] |=> st.relock == CDS_RL_IDLE;
    endproperty
    a_restorer_gate: assert property (p_restorer_gate)
        else $error("relock tracking active with restorer off");

    property p_relock_time;
        @(posedge clk) disable iff (srst)
        $rose(st.relock == CDS_RL_LOCKED)
            |-> $past(st.relock_cnt) == RELOCK_W'(RELOCK_CYCLES - 1);
    endproperty
    a_relock_time: assert property (p_relock_time)
        else $error("restorer reported locked before the relock time");

    property p_ref_select;
        @(posedge clk) disable iff (srst)
        sense_low |=> ref_internal && !ref_external;
    endproperty
    a_ref_select: assert property (p_ref_select)
        else $error("internal reference not selected with sense low");

    property p_ref_external;
        @(posedge clk) disable iff (srst)
        sense_high && !sense_low |=> ref_external && !ref_internal;
    endproperty
    a_ref_external: assert property (p_ref_external)
        else $error("external reference not selected with sense high");

    property p_write_div;
        @(posedge clk) disable iff (srst)
        wr_div |=> st.div_control == ($past(wdata) & DIV_CONTROL_MASK);
    endproperty
    a_write_div: assert property (p_write_div)
        else $error("div_control write not stored");

    property p_relock_restart;
        @(posedge clk) disable iff (srst)
        restorer_active && div_change |=> st.relock == CDS_RL_WAIT && st.relock_cnt == '0;
    endproperty
    a_relock_restart: assert property (p_relock_restart)
        else $error("relock wait not restarted after a divider change");

    property p_oneshot_accept;
        @(posedge clk) disable iff (srst)
        accept && one_shot |=> st.realign ##1 sample_strobe && phase == 3'h0;
    endproperty
    a_oneshot_accept: assert property (p_oneshot_accept)
        else $error("first sync in one-shot mode did not reset the divider");

    property p_readdata_hold;
        @(posedge clk) disable iff (srst)
        !(avs_read && avs_waitrequest) |=> $stable(avs_readdata);
    endproperty
    a_readdata_hold: assert property (p_readdata_hold)
        else $error("read data changed without a captured read");

    property p_idle_wait;
        @(posedge clk) disable iff (srst)
        !bus_req |=> avs_waitrequest;
    endproperty
    a_idle_wait: assert property (p_idle_wait)
        else $error("waitrequest low without a request");

    c_oneshot_accept: cover property (@(posedge clk) disable iff (srst) accept && one_shot);
    c_every_accept: cover property (@(posedge clk) disable iff (srst) accept && !one_shot);
    c_relocked: cover property (@(posedge clk) disable iff (srst)
        $rose(st.relock == CDS_RL_LOCKED));
    c_status_read: cover property (@(posedge clk) disable iff (srst)
        avs_read && !avs_waitrequest && cds_decode(avs_address) == CDS_SEL_STATUS);

endmodule

// ===== cds_pkg.sv
// Shared constants, types and decode for the sample-clock divider and sync block
package cds_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int CLK_HZ = 25_000_000;
    localparam int RESTORER_MIN_HZ = 20_000_000;
    localparam int RELOCK_MIN_NS = 1500;
    localparam int RELOCK_MAX_NS = 5000;
    localparam int RELOCK_CYCLES = (RELOCK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam bit RESTORER_SUPPORTED = (CLK_HZ >= RESTORER_MIN_HZ);
    localparam int RELOCK_W = 6;

    // Divider
    localparam int RATIO_MIN = 1;
    localparam int RATIO_MAX = 8;
    localparam int CNT_W = 3;

    // Bus
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;

    // Register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] SYNC_CONTROL_OFS = 9'h100;
    localparam logic [ADDR_W-1:0] DIV_CONTROL_OFS = 9'h104;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 9'h108;

    // Reset values and writable masks
    localparam logic [7:0] SYNC_CONTROL_RST = 8'h00;
    localparam logic [7:0] SYNC_CONTROL_MASK = 8'h06;
    localparam logic [7:0] DIV_CONTROL_RST = 8'h00;
    localparam logic [7:0] DIV_CONTROL_MASK = 8'h0F;

    // sync_control fields
    localparam int SC_SYNC_EN_BIT = 1;
    localparam int SC_ONE_SHOT_BIT = 2;

    // div_control fields
    localparam int DC_RATIO_LSB = 0;
    localparam int DC_RESTORER_BIT = 3;

    // status fields
    localparam int ST_ARMED_BIT = 0;
    localparam int ST_RESTORER_BIT = 1;
    localparam int ST_LOCKED_BIT = 2;
    localparam int ST_REF_INT_BIT = 3;
    localparam int ST_REF_EXT_BIT = 4;
    localparam int ST_PHASE_LSB = 5;

    typedef enum logic [1:0] {
        CDS_SEL_NONE,
        CDS_SEL_SYNC,
        CDS_SEL_DIV,
        CDS_SEL_STATUS
    } cds_sel_t;

    typedef enum logic [1:0] {
        CDS_RL_IDLE,
        CDS_RL_WAIT,
        CDS_RL_LOCKED
    } cds_relock_t;

    function automatic cds_sel_t cds_decode(input logic [ADDR_W-1:0] addr);
        cds_sel_t sel;
        sel = CDS_SEL_NONE;
        if (addr == SYNC_CONTROL_OFS)
            sel = CDS_SEL_SYNC;
        else if (addr == DIV_CONTROL_OFS)
            sel = CDS_SEL_DIV;
        else if (addr == STATUS_OFS)
            sel = CDS_SEL_STATUS;
        return sel;
    endfunction

endpackage

// ===== cds_sync2.sv
// Two-flop synchroniser for the external sync input
`timescale 1ns/100ps
module cds_sync2
    import cds_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Data
    input wire logic d,
    output logic q
);

    typedef struct packed {
        logic s1;
        logic s2;
    } cds_sync_state_t;

    cds_sync_state_t st;
    cds_sync_state_t next_st;

    always_comb
    begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            st <= '0;
        else
            st <= next_st;
    end

    assign q = st.s2;

    property p_sync_latency;
        @(posedge clk) disable iff (srst)
        !$past(srst) && !$past(srst, 2) |-> q == $past(d, 2);
    endproperty
    a_sync_latency: assert property (p_sync_latency)
        else $error("sync output is not the input delayed by two cycles");

endmodule

// ===== cds_divider.sv
// Integer divider producing the conversion clock and sample strobe
`timescale 1ns/100ps
module cds_divider
    import cds_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Control
    input wire logic [CNT_W-1:0] ratio_m1,
    input wire logic restorer_on,
    input wire logic realign,
    // Outputs
    output logic conv_clk,
    output logic sample_strobe,
    output logic [CNT_W-1:0] phase
);

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic conv_clk;
        logic strobe;
    } cds_div_state_t;

    cds_div_state_t st;
    cds_div_state_t next_st;
    logic [CNT_W:0] ratio;
    logic [CNT_W:0] high_len;

    always_comb
    begin
        next_st = st;
        ratio = {1'b0, ratio_m1} + 4'h1;
        // Restorer: high for half the period rounded down (at least one cycle), else a one-cycle pulse
        high_len = restorer_on ? (ratio >> 1) : 4'h1;
        if (high_len == 4'h0)
            high_len = 4'h1;
        if (realign)
            next_st.count = '0;
        else if (st.count >= ratio_m1)
            next_st.count = '0;
        else
            next_st.count = st.count + 3'h1;
        next_st.conv_clk = ({1'b0, next_st.count} < high_len);
        next_st.strobe = (next_st.count == 3'h0);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            st <= '0;
        else
            st <= next_st;
    end

    assign conv_clk = st.conv_clk;
    assign sample_strobe = st.strobe;
    assign phase = st.count;

    // Helper: strobe spacing tracking
    logic [CNT_W:0] gap;
    logic disturbed;
    logic seen;
    logic [CNT_W-1:0] ratio_q;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            gap <= '0;
            disturbed <= 1'b1;
            seen <= 1'b0;
            ratio_q <= '0;
        end
        else
        begin
            ratio_q <= ratio_m1;
            if (st.strobe)
            begin
                gap <= '0;
                seen <= 1'b1;
                disturbed <= realign || (ratio_m1 != ratio_q);
            end
            else
            begin
                gap <= gap + 4'h1;
                disturbed <= disturbed || realign || (ratio_m1 != ratio_q);
            end
        end
    end

    property p_period;
        @(posedge clk) disable iff (srst)
        sample_strobe && seen && !disturbed |-> gap == {1'b0, $past(ratio_m1)};
    endproperty
    a_period: assert property (p_period)
        else $error("sample strobe spacing differs from the divide ratio");

    property p_realign;
        @(posedge clk) disable iff (srst)
        realign |=> sample_strobe && phase == 3'h0;
    endproperty
    a_realign: assert property (p_realign)
        else $error("divider not at its initial state after realign");

    property p_duty_div2;
        @(posedge clk) disable iff (srst)
        (restorer_on && ratio_m1 == 3'h1 && !realign) [*3] |-> conv_clk != $past(conv_clk);
    endproperty
    a_duty_div2: assert property (p_duty_div2)
        else $error("restored clock does not toggle each cycle at divide by two");

    property p_strobe_rise;
        @(posedge clk) disable iff (srst)
        sample_strobe |-> conv_clk;
    endproperty
    a_strobe_rise: assert property (p_strobe_rise)
        else $error("sample strobe outside the high phase of the conversion clock");

endmodule

// ===== cds_sync_src.sv
// Board-side model driving the sync pin and the reference sense comparators
`timescale 1ns/100ps
module cds_sync_src
(
    // Clock
    input wire logic clk,
    // Board signals
    output logic sync_in,
    output logic sense_low,
    output logic sense_high
);
    initial
    begin
        sync_in = 1'b0;
        sense_low = 1'b1;
        sense_high = 1'b0;
    end

    // One-cycle pulse launched just after a sample clock edge
    task automatic pulse();
        @(posedge clk);
        sync_in <= 1'b1;
        @(posedge clk);
        sync_in <= 1'b0;
    endtask

    // Sense pin level: 0 ground, 1 analog supply, 2 in between
    task automatic set_sense(input int mode);
        @(posedge clk);
        sense_low <= (mode == 0);
        sense_high <= (mode == 1);
    endtask
endmodule

// ===== tb_clock_divider_sync.sv
// Self-checking bench for the divider, sync alignment and reference select
`timescale 1ns/100ps
module tb_clock_divider_sync;
    import cds_pkg::*;

    logic clk;
    logic srst;
    logic [ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [DATA_W-1:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic sync_in;
    logic sense_low;
    logic sense_high;
    logic conv_clk;
    logic sample_strobe;
    logic ref_internal;
    logic ref_external;
    int err_total;
    int comparisons;
    int cyc;
    int last_hi;

    cds_top i_dut (
        .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sync_in(sync_in), .sense_low(sense_low),
        .sense_high(sense_high), .conv_clk(conv_clk), .sample_strobe(sample_strobe),
        .ref_internal(ref_internal), .ref_external(ref_external)
    );

    cds_sync_src i_src (
        .clk(clk), .sync_in(sync_in), .sense_low(sense_low), .sense_high(sense_high)
    );

    always #20 clk = ~clk;

    task automatic finish_test();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Cycle count, timeout and last strobe position
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            err_total++;
            finish_test();
        end
    end

    always @(negedge clk)
    begin
        if (sample_strobe === 1'b1)
            last_hi <= cyc;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t seen=%0h expected=%0h", $time, seen, exp);
        end
    endtask

    task automatic bus_cycle(input logic wr, input logic [ADDR_W-1:0] a,
                             input logic [31:0] d, input logic [3:0] be,
                             output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        // Hold the request until waitrequest is sampled low at a rising edge
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_cycle(1'b1, a, d, 4'hF, q);
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] m,
                          input logic [31:0] exp);
        logic [31:0] q;
        bus_cycle(1'b0, a, 32'h0, 4'hF, q);
        check(q & m, exp);
    endtask

    function automatic int exp_high(input int r, input bit on);
        if (on && r / 2 > 1)
            return r / 2;
        return 1;
    endfunction

    // One full period from a strobe: strobe count, high time, period length
    task automatic div_check(input int r, input bit on);
        int hs;
        int hc;
        int n;
        n = 0;
        hs = 0;
        hc = 0;
        repeat (16) @(negedge clk);
        while (sample_strobe !== 1'b1 && n < 20)
        begin
            n++;
            @(negedge clk);
        end
        check(conv_clk, 1'b1);
        repeat (r)
        begin
            hs += (sample_strobe === 1'b1);
            hc += (conv_clk === 1'b1);
            @(negedge clk);
        end
        check(sample_strobe, 1'b1);
        check(hs, 1);
        check(hc, exp_high(r, on));
    endtask

    // Pulse sync; a realign puts the strobe three edges after it is sampled
    task automatic sync_check(input int r, input bit taken);
        logic pred;
        repeat ($urandom_range(0, 9)) @(posedge clk);
        i_src.pulse();
        repeat (3) @(posedge clk);
        @(negedge clk);
        pred = ((cyc - last_hi) % r) == 0;
        check(sample_strobe, taken ? 1'b1 : pred);
        @(negedge clk);
        pred = taken ? (r == 1) : (((cyc - last_hi) % r) == 0);
        check(sample_strobe, pred);
    endtask

    initial
    begin
        int r;
        logic [31:0] q;
        clk = 1'b0;
        srst = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'h0;
        err_total = 0;
        comparisons = 0;
        cyc = 0;
        last_hi = 0;
        void'($urandom(32'hf4d1b0d3));
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        // Reset values, masks, refused writes
        rd_chk(SYNC_CONTROL_OFS, 32'hFFFFFFFF, 32'h00);
        rd_chk(DIV_CONTROL_OFS, 32'hFFFFFFFF, 32'h00);
        rd_chk(9'h0FC, 32'hFFFFFFFF, 32'h00);
        wr(SYNC_CONTROL_OFS, 32'hFFFFFFFF);
        rd_chk(SYNC_CONTROL_OFS, 32'hFFFFFFFF, 32'h06);
        bus_cycle(1'b1, SYNC_CONTROL_OFS, 32'h0, 4'hE, q);
        rd_chk(SYNC_CONTROL_OFS, 32'hFFFFFFFF, 32'h06);
        wr(9'h10C, 32'hFF);
        rd_chk(9'h10C, 32'hFFFFFFFF, 32'h00);
        wr(SYNC_CONTROL_OFS, 32'h0);
        // Every ratio; restorer forced on where advised
        for (int i = 1; i <= 8; i++)
        begin
            for (int on = (i == 1 || i == 2 || i == 4) ? 0 : 1; on <= 1; on++)
            begin
                wr(DIV_CONTROL_OFS, (i - 1) | (on << 3));
                rd_chk(DIV_CONTROL_OFS, 32'hFFFFFFFF, (i - 1) | (on << 3));
                div_check(i, on);
            end
        end
        // Restorer active, then locked after the relock wait
        wr(DIV_CONTROL_OFS, 32'h0B);
        rd_chk(STATUS_OFS, 32'h06, {1'b0, RESTORER_SUPPORTED} << 1);
        repeat (RELOCK_CYCLES + 5) @(posedge clk);
        rd_chk(STATUS_OFS, 32'h06, 32'h06);
        // Resync on every pulse, random ratios
        wr(SYNC_CONTROL_OFS, 32'h02);
        repeat (6)
        begin
            r = $urandom_range(1, 8);
            wr(DIV_CONTROL_OFS, (r - 1) | 8);
            sync_check(r, 1'b1);
        end
        // Sync disabled
        wr(DIV_CONTROL_OFS, 32'h0E);
        wr(SYNC_CONTROL_OFS, 32'h00);
        repeat (20) @(posedge clk);
        repeat (2) sync_check(7, 1'b0);
        // One-shot: first taken, later ignored, rewrite rearms
        wr(SYNC_CONTROL_OFS, 32'h06);
        rd_chk(STATUS_OFS, 32'h01, 32'h01);
        sync_check(7, 1'b1);
        rd_chk(STATUS_OFS, 32'h01, 32'h00);
        repeat (2) sync_check(7, 1'b0);
        wr(SYNC_CONTROL_OFS, 32'h06);
        sync_check(7, 1'b1);
        // Reference select from the sense comparators
        for (int m = 0; m < 3; m++)
        begin
            i_src.set_sense(m);
            @(posedge clk);
            @(negedge clk);
            check(ref_internal, m == 0);
            check(ref_external, m == 1);
            rd_chk(STATUS_OFS, 32'h18, {m == 1, m == 0} << 3);
        end
        finish_test();
    end
endmodule
